/* File: dms_top.sv */
/*
  Front-panel display selector: scroll ring, frozen measurements, adjust
  buttons, injection rate and an AXI4-Lite register slave.
  Assumes button and detector-on pins are asynchronous; counters are
  on clk.
*/
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dms_regs.svh"
// What this block does
// - Scroll up selects the previous item
// - Scroll down selects the next item
// - Scrolling wraps around both ends
// - BER is errored bits over all bits
// - Detector on: BER recomputed continuously
// - Detector off: BER holds last result
// - Detector on: seconds count upward
// - Detector off: seconds hold their value
// - External clock: frequency 500 MHz to 12.5 GHz
// - Phase shown in degrees, 0 to 358
// - Plus on phase starts autophase search
// - Ten settings, plus/minus change shown one
// - Config lamp stays lit across settings
// - No per-setting lamp, text identifies setting
// - Injection rate OFF or 1E0 to 1E7
// - Amplitude per side, differential doubled
// - Display shows last four serial digits
// - Injection inverts that many bits per second
module dms_top
  import dms_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = `DMS_SECOND_S * `DMS_CLK_HZ,
  parameter logic [15:0] FREQ_INT_MIN  = `DMS_FREQ_EXT_MIN,
  parameter logic [15:0] FREQ_INT_MAX  = `DMS_FREQ_EXT_MAX,
  parameter logic [31:0] IDENT_SERIAL  = 32'h00005a3c, // Arbitrary value
  parameter logic [15:0] IDENT_FW      = 16'h0001       // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Front-panel buttons
  input  wire logic        btn_scroll_up,
  input  wire logic        btn_scroll_down,
  input  wire logic        btn_adjust_plus,
  input  wire logic        btn_adjust_minus,
  // Error detector
  input  wire logic        detector_on,
  input  wire logic [31:0] errored_bits,
  input  wire logic [31:0] total_bits,
  // Display and actions
  output var  logic [5:0]  item_lamp,
  output var  logic [3:0]  display_pos,
  output var  logic [31:0] display_value,
  output var  logic        autophase_start,
  output var  logic        error_inject,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  dms_top_s    q;
  dms_top_s    n;
  dms_div_if   div_if ();
  logic        up_e;
  logic        dn_e;
  logic        pl_e;
  logic        mi_e;
  logic        det_rise;
  logic        tick;
  logic [23:0] inj_step;
  logic [3:0]  cfg_k;
  logic [3:0]  cfg_cur;
  logic [3:0]  cfg_max;
  logic [31:0] wmask;
  logic [15:0] f_lo;
  logic [15:0] f_hi;

  localparam logic [39:0] CFG_MAX = `DMS_CFG_MAX;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `DMS_A_FWREV);
  endfunction

  // Edges read only the second synchroniser stage onward
  assign up_e     = q.btn_s[0] & ~q.btn_p[0];
  assign dn_e     = q.btn_s[1] & ~q.btn_p[1];
  assign pl_e     = q.btn_s[2] & ~q.btn_p[2];
  assign mi_e     = q.btn_s[3] & ~q.btn_p[3];
  assign det_rise = q.det_s & ~q.det_p;
  assign cfg_k    = q.pos - `DMS_POS_CFG;
  assign cfg_cur  = q.cfg[{cfg_k, 2'b00} +: 4];
  assign cfg_max  = CFG_MAX[{cfg_k, 2'b00} +: 4];

  // Errors per second for each injection code
  always_comb begin
    case (q.cfg[`DMS_CFG_INJ*4 +: 4])
      4'h1:    inj_step = 24'h000001;
      4'h2:    inj_step = 24'h00000a;
      4'h3:    inj_step = 24'h000064;
      4'h4:    inj_step = 24'h0003e8;
      4'h5:    inj_step = 24'h002710;
      4'h6:    inj_step = 24'h0186a0;
      4'h7:    inj_step = 24'h0f4240;
      4'h8:    inj_step = 24'h989680;
      default: inj_step = 24'h000000;
    endcase
  end

  always_comb begin
    n         = q;
    wmask     = 32'h0;
    f_lo      = FREQ_INT_MIN;
    f_hi      = FREQ_INT_MAX;
    n.btn_m   = {btn_adjust_minus, btn_adjust_plus, btn_scroll_down, btn_scroll_up};
    n.btn_s   = q.btn_m;
    n.btn_p   = q.btn_s;
    n.det_m   = detector_on;
    n.det_s   = q.det_m;
    n.det_p   = q.det_s;
    n.auto_go = 1'b0;
    n.div_go  = 1'b0;
    // Display ring
    if (up_e && !dn_e) begin
      n.pos = (q.pos == 4'h0) ? `DMS_POS_LAST : q.pos - 4'h1;
    end else if (dn_e && !up_e) begin
      n.pos = (q.pos == `DMS_POS_LAST) ? 4'h0 : q.pos + 4'h1;
    end
    // Adjust buttons
    if (pl_e && q.pos == `DMS_POS_PHASE) begin
      n.auto_go = 1'b1;
    end
    if (q.pos >= `DMS_POS_CFG && q.pos != `DMS_POS_LAST) begin
      if (pl_e && !mi_e && cfg_cur < cfg_max) begin
        n.cfg[{cfg_k, 2'b00} +: 4] = cfg_cur + 4'h1;
      end else if (mi_e && !pl_e && cfg_cur != 4'h0) begin
        n.cfg[{cfg_k, 2'b00} +: 4] = cfg_cur - 4'h1;
      end
    end
    // Elapsed seconds restart with each session
    if (det_rise) begin
      n.secs = 32'h0;
    end else if (q.det_s && tick) begin
      n.secs = q.secs + 32'h1;
    end
    // Ratio restarts back to back while the detector is on
    if (q.det_s && !div_if.busy && !q.div_go) begin
      n.div_go = 1'b1;
    end
    if (div_if.done && q.det_s) begin
      n.ber = div_if.quo;
    end
    // AXI write channels
    if (s_axi_awvalid && q.awready) begin
      n.aw_hold = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_hold = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(q.awaddr) ? `DMS_RESP_OKAY : `DMS_RESP_SLVERR;
      case (q.awaddr)
        `DMS_A_AMPL: begin
          wmask  = merge({16'h0, q.ampl}, q.wdata, q.wstrb);
          n.ampl = wmask[15:0];
        end
        `DMS_A_FREQ: begin
          wmask  = merge({16'h0, q.freq}, q.wdata, q.wstrb);
          n.freq = wmask[15:0];
        end
        `DMS_A_PHASE: begin
          wmask   = merge({23'h0, q.phase}, q.wdata, q.wstrb);
          n.phase = (wmask > {23'h0, `DMS_PHASE_MAX}) ? `DMS_PHASE_MAX : wmask[8:0];
        end
        `DMS_A_CFGLO: begin
          n.cfg[31:0] = merge(q.cfg[31:0], q.wdata, q.wstrb);
        end
        `DMS_A_CFGHI: begin
          wmask        = merge({24'h0, q.cfg[39:32]}, q.wdata, q.wstrb);
          n.cfg[39:32] = wmask[7:0];
        end
        default: begin
        end
      endcase
    end
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready  = !n.w_hold && !n.bvalid;
    // Frequency kept inside the range of the selected clock source
    if (n.cfg[`DMS_CFG_SYNTH*4 +: 4] == 4'h0) begin
      f_lo = `DMS_FREQ_EXT_MIN;
      f_hi = `DMS_FREQ_EXT_MAX;
    end
    if (n.freq < f_lo) begin
      n.freq = f_lo;
    end else if (n.freq > f_hi) begin
      n.freq = f_hi;
    end
    // AXI read channels
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(s_axi_araddr) ? `DMS_RESP_OKAY : `DMS_RESP_SLVERR;
      case (s_axi_araddr)
        `DMS_A_STATUS: n.rdata = {21'h0, q.det_s, q.lamp, q.pos};
        `DMS_A_BER:    n.rdata = q.ber;
        `DMS_A_TIME:   n.rdata = q.secs;
        `DMS_A_AMPL:   n.rdata = {q.ampl[14:0], 1'b0, q.ampl};
        `DMS_A_FREQ:   n.rdata = {16'h0, q.freq};
        `DMS_A_PHASE:  n.rdata = {23'h0, q.phase};
        `DMS_A_CFGLO:  n.rdata = q.cfg[31:0];
        `DMS_A_CFGHI:  n.rdata = {24'h0, q.cfg[39:32]};
        `DMS_A_SERIAL: n.rdata = IDENT_SERIAL;
        `DMS_A_FWREV:  n.rdata = {16'h0, IDENT_FW};
        default:       n.rdata = 32'h0;
      endcase
    end
    n.arready = !n.rvalid;
    // One lamp per main item; all settings share the last one
    n.lamp = (n.pos >= `DMS_POS_CFG) ? 6'h20 : 6'(6'h01 << n.pos);
    case (n.pos)
      4'h0:          n.shown = n.ber;
      4'h1:          n.shown = n.secs;
      4'h2:          n.shown = {16'h0, n.ampl};
      4'h3:          n.shown = {16'h0, n.freq};
      4'h4:          n.shown = {23'h0, n.phase};
      `DMS_POS_LAST: n.shown = {IDENT_FW, IDENT_SERIAL[15:0]};
      default:       n.shown = {28'h0, n.cfg[{n.pos - `DMS_POS_CFG, 2'b00} +: 4]};
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q       <= '0;
      q.ampl  <= `DMS_RST_AMPL;
      q.freq  <= `DMS_RST_FREQ;
      q.phase <= `DMS_RST_PHASE;
      q.cfg   <= `DMS_RST_CFG;
      q.lamp  <= 6'h01;
    end else begin
      q <= n;
    end
  end

  assign div_if.start = q.div_go;
  assign div_if.num   = errored_bits;
  assign div_if.den   = total_bits;

  dms_div u_div (
    .clk   (clk),
    .reset (reset),
    .d     (div_if.rsp)
  );

  dms_rate #(.CLK_HZ(SECOND_CYCLES)) u_second (
    .clk   (clk),
    .reset (reset),
    .clr   (det_rise),
    .step  (24'h000001),
    .pulse (tick)
  );

  dms_rate #(.CLK_HZ(SECOND_CYCLES)) u_inject (
    .clk   (clk),
    .reset (reset),
    .clr   (inj_step == 24'h0),
    .step  (inj_step),
    .pulse (error_inject)
  );

  assign item_lamp       = q.lamp;
  assign display_pos     = q.pos;
  assign display_value   = q.shown;
  assign autophase_start = q.auto_go;
  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.arready;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rresp     = q.rresp;
  assign s_axi_rdata     = q.rdata;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_scroll_up_prev: assert property (up_e && !dn_e && q.pos != 4'h0
    |=> q.pos == $past(q.pos) - 4'h1) else $error("scroll up wrong");
  a_scroll_dn_next: assert property (dn_e && !up_e && q.pos != `DMS_POS_LAST
    |=> q.pos == $past(q.pos) + 4'h1) else $error("scroll down wrong");
  a_scroll_wrap_dn: assert property (dn_e && !up_e && q.pos == `DMS_POS_LAST
    |=> q.pos == 4'h0) else $error("no wrap to first");
  a_scroll_wrap_up: assert property (up_e && !dn_e && q.pos == 4'h0
    |=> q.pos == `DMS_POS_LAST) else $error("no wrap to last");
  sequence s_ratio_ready;
    div_if.done && q.det_s;
  endsequence
  a_ber_live_take: assert property (s_ratio_ready
    |=> q.ber == $past(div_if.quo)) else $error("ratio not shown");
  a_ber_frozen_off: assert property (!q.det_s |=> $stable(q.ber))
    else $error("ratio moved while off");
  a_time_step_up: assert property (q.det_s && tick && !det_rise
    |=> q.secs == $past(q.secs) + 32'h1) else $error("seconds not counted");
  a_time_frozen_off: assert property (!q.det_s |=> $stable(q.secs))
    else $error("seconds moved while off");
  a_freq_ext_range: assert property (q.cfg[`DMS_CFG_SYNTH*4 +: 4] == 4'h0
    |-> q.freq >= `DMS_FREQ_EXT_MIN && q.freq <= `DMS_FREQ_EXT_MAX)
    else $error("frequency out of range");
  a_phase_span_max: assert property (q.phase <= `DMS_PHASE_MAX)
    else $error("phase above limit");
  a_autophase_go: assert property (pl_e && q.pos == `DMS_POS_PHASE
    |=> autophase_start ##1 !autophase_start) else $error("autophase not started");
  a_cfg_adjust_up: assert property (pl_e && !mi_e && !up_e && !dn_e
    && q.pos >= `DMS_POS_CFG && q.pos != `DMS_POS_LAST && cfg_cur < cfg_max
    |=> cfg_cur == $past(cfg_cur) + 4'h1) else $error("setting not raised");
  a_cfg_lamp_lit: assert property (q.pos >= `DMS_POS_CFG |-> q.lamp == 6'h20)
    else $error("config lamp not lit");
endmodule
`default_nettype wire

/* File: dms_regs.svh */
/*
  Constants of the display selector: register offsets, reset values,
  ring positions, limits and timing. Included by the modules that use them.
*/
`ifndef DMS_REGS_SVH
`define DMS_REGS_SVH

`define DMS_CLK_HZ        25000000
`define DMS_SECOND_S      1
`define DMS_A_STATUS      8'h00
`define DMS_A_BER         8'h04
`define DMS_A_TIME        8'h08
`define DMS_A_AMPL        8'h0c
`define DMS_A_FREQ        8'h10
`define DMS_A_PHASE       8'h14
`define DMS_A_CFGLO       8'h18
`define DMS_A_CFGHI       8'h1c
`define DMS_A_SERIAL      8'h20
`define DMS_A_FWREV       8'h24
`define DMS_POS_PHASE     4'h4
`define DMS_POS_CFG       4'h5
`define DMS_POS_LAST      4'hf
`define DMS_PHASE_MAX     9'h166
`define DMS_FREQ_EXT_MIN  16'h01f4
`define DMS_FREQ_EXT_MAX  16'h30d4
`define DMS_RST_FREQ      16'h2710
`define DMS_RST_AMPL      16'h01f4
`define DMS_RST_PHASE     9'h000
`define DMS_RST_CFG       40'h0000001083
`define DMS_CFG_MAX       40'h0ff18011f3
`define DMS_CFG_SYNTH     3
`define DMS_CFG_INJ       5
`define DMS_RESP_OKAY     2'h0
`define DMS_RESP_SLVERR   2'h2

`endif

/* File: dms_pkg.sv */
/*
  Types of the display selector: item enumeration and state records.
  Assumes dms_regs.svh is on the include path.
*/
package dms_pkg;
  typedef enum logic [2:0] {ITEM_BER, ITEM_TIME, ITEM_AMPL, ITEM_FREQ, ITEM_PHASE,
                            ITEM_CFG} dms_item_e;

  typedef struct packed {
    logic [31:0] acc;
    logic        pulse;
  } dms_rate_s;

  typedef struct packed {
    logic [31:0] rem;
    logic [31:0] den;
    logic [31:0] quo;
    logic [5:0]  cnt;
    logic        busy;
    logic        done;
    logic        sat;
    logic        zero;
  } dms_div_s;

  typedef struct packed {
    logic [3:0]  btn_m;
    logic [3:0]  btn_s;
    logic [3:0]  btn_p;
    logic        det_m;
    logic        det_s;
    logic        det_p;
    logic [3:0]  pos;
    logic [5:0]  lamp;
    logic [31:0] shown;
    logic [31:0] ber;
    logic [31:0] secs;
    logic [15:0] ampl;
    logic [15:0] freq;
    logic [8:0]  phase;
    logic [39:0] cfg;
    logic        auto_go;
    logic        div_go;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        aw_hold;
    logic        w_hold;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } dms_top_s;
endpackage

/* File: dms_div_if.sv */
/*
  Request and answer of the ratio divider.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface dms_div_if;
  logic        start;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quo;
  logic        busy;
  logic        done;
  modport req (output start, num, den, input quo, busy, done);
  modport rsp (input start, num, den, output quo, busy, done);
endinterface
`default_nettype wire

/* File: dms_rate.sv */
/*
  Rate pulse generator: one-cycle pulses at step per second on average.
  Assumes step stays below CLK_HZ and a clock of CLK_HZ.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dms_regs.svh"
module dms_rate
  import dms_pkg::*;
#(
  parameter int unsigned CLK_HZ = `DMS_CLK_HZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Rate control
  input  wire logic        clr,
  input  wire logic [23:0] step,
  // Pulse out
  output var  logic        pulse
);
  dms_rate_s   q;
  dms_rate_s   n;
  logic [31:0] sum;

  always_comb begin
    n       = q;
    n.pulse = 1'b0;
    sum     = q.acc + {8'h00, step};
    if (clr) begin
      n.acc = 32'h0;
    end else if (sum >= CLK_HZ) begin
      n.acc   = sum - CLK_HZ;
      n.pulse = 1'b1;
    end else begin
      n.acc = sum;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pulse = q.pulse;

  a_rate_off_quiet: assert property (@(posedge clk) disable iff (reset)
    (clr || step == 24'h0) |=> !pulse) else $error("pulse while rate off");
endmodule
`default_nettype wire

/* File: dms_div.sv */
/*
  Sequential ratio divider: quo = num * 2^32 / den, 32 steps.
  Assumes num and den are steady in the start cycle only.
*/
`timescale 1ns/10ps
`default_nettype none
module dms_div
  import dms_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Divider port
  dms_div_if.rsp    d
);
  dms_div_s    q;
  dms_div_s    n;
  logic [32:0] r2;
  logic [5:0]  busy_run;

  always_comb begin
    n      = q;
    n.done = 1'b0;
    r2     = {q.rem, 1'b0};
    if (!q.busy && d.start) begin
      n.rem  = d.num;
      n.den  = d.den;
      n.quo  = 32'h0;
      n.cnt  = 6'h20;
      n.busy = 1'b1;
      n.zero = (d.den == 32'h0);
      n.sat  = (d.num >= d.den);
    end else if (q.busy) begin
      if (r2 >= {1'b0, q.den}) begin
        n.rem = 32'(r2 - {1'b0, q.den});
        n.quo = {q.quo[30:0], 1'b1};
      end else begin
        n.rem = r2[31:0];
        n.quo = {q.quo[30:0], 1'b0};
      end
      n.cnt = q.cnt - 6'h1;
      if (q.cnt == 6'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        if (q.zero) begin
          n.quo = 32'h0;
        end else if (q.sat) begin
          n.quo = 32'hffffffff;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign d.quo  = q.quo;
  assign d.busy = q.busy;
  assign d.done = q.done;

  // Length of the current busy run, for the latency checks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_run <= 6'h0;
    end else begin
      busy_run <= d.busy ? busy_run + 6'h1 : 6'h0;
    end
  end

  sequence s_div_end;
    d.done && !d.busy && busy_run == 6'h20;
  endsequence
  a_div_latency: assert property (@(posedge clk) disable iff (reset)
    $fell(d.busy) |-> s_div_end) else $error("divider latency wrong");
  a_div_no_overrun: assert property (@(posedge clk) disable iff (reset)
    d.busy |-> busy_run < 6'h20) else $error("divider ran too long");
endmodule
`default_nettype wire

/* File: dms_panel.sv */
/*
  Front-panel model: presses the four buttons and counts the one-cycle
  action pulses. Assumes the clock of the display selector.
*/
`timescale 1ns/10ps
`default_nettype none
module dms_panel (
  // Clock
  input  wire logic       clk,
  // Buttons: up, down, plus, minus
  output var  logic [3:0] btn,
  // Action pulses
  input  wire logic       autophase_start,
  input  wire logic       error_inject
);
  int n_auto = 0;
  int n_inj  = 0;
  initial btn = 4'h0;
  always @(posedge clk) begin
    if (autophase_start === 1'b1) n_auto <= n_auto + 1;
    if (error_inject === 1'b1) n_inj <= n_inj + 1;
  end
  // Level held well past the synchroniser, then released as long
  task automatic press(input int k);
    @(posedge clk);
    btn[k] <= 1'b1;
    repeat (6) @(posedge clk);
    btn[k] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dms_top_bench.sv */
/*
  Self-checking bench of the display selector: AXI4-Lite tasks, button
  presses through the panel model and compares against fixed values.
  Assumes a one-second count of 100 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module dms_top_bench;
  import dms_pkg::*;
  localparam int SEC = 100;
  logic clk = 1'b0, reset, det;
  logic [31:0] err_b, tot_b, wdata, rd;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, apulse, inj;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] btn, pos;
  logic [5:0] lamp;
  logic [31:0] dval, rdata;
  int n_fail = 0, checks = 0, t1, k;
  always #20 clk = ~clk;
  dms_panel u_dms_panel (.clk(clk), .btn(btn), .autophase_start(apulse), .error_inject(inj));
  dms_top #(.SECOND_CYCLES(SEC)) u_dms_top (.clk(clk), .reset(reset),
    .btn_scroll_up(btn[0]), .btn_scroll_down(btn[1]), .btn_adjust_plus(btn[2]),
    .btn_adjust_minus(btn[3]), .detector_on(det), .errored_bits(err_b), .total_bits(tot_b),
    .item_lamp(lamp), .display_pos(pos), .display_value(dval), .autophase_start(apulse),
    .error_inject(inj), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t %s: response %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic hang();
    n_fail++;
    $display("ERROR %0t bus wait ran out", $time);
    end_of_test();
  endtask
  // Address and data offered together, each released at its own handshake
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw_ok, w_ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 0;
    w_ok = 0;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1 && aw_ok && w_ok) break;
    end
    if (n == 100) hang();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar_ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_ok = 0;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1 && ar_ok) break;
    end
    if (n == 100) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    axr(a, rd, rs);
    cmp_resp(rs, 2'h0, m);
    cmp_val(rd, e, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, rs);
    cmp_resp(rs, 2'h0, "write");
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    hang();
  end
  initial begin
    reset <= 1'b1;
    det <= 1'b0;
    {err_b, tot_b, wdata} <= 96'h0;
    {awaddr, araddr} <= 16'h0;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(8'h00, 32'h00000010, "status reset");
    rchk(8'h0c, 32'h03e801f4, "ampl per side and doubled");
    rchk(8'h10, 32'h00002710, "freq reset");
    rchk(8'h18, 32'h00001083, "cfg reset");
    axr(8'h40, rd, rs);
    cmp_resp(rs, 2'h2, "unmapped read");
    axw(8'h40, 32'h0, rs);
    cmp_resp(rs, 2'h2, "unmapped write");
    wstrb <= 4'h1;
    wr(8'h0c, 32'h12345678);
    wstrb <= 4'hf;
    rchk(8'h0c, 32'h02f00178, "ampl low lane only");
    $display("Test reset done");
    for (k = 1; k <= 16; k++) begin
      u_dms_panel.press(1);
      cmp_val({28'h0, pos}, k % 16, "scroll down");
      cmp_val({26'h0, lamp}, (k % 16 < 5) ? 1 << (k % 16) : 32'h20, "lamp");
      if (k == 15) cmp_val(dval, 32'h00015a3c, "ident shown");
    end
    u_dms_panel.press(0);
    cmp_val({28'h0, pos}, 32'hf, "scroll up wraps");
    u_dms_panel.press(0);
    cmp_val({28'h0, pos}, 32'he, "scroll up");
    $display("Test ring done");
    wr(8'h14, 32'h00000190);
    rchk(8'h14, 32'h00000166, "phase clamp");
    for (k = 0; k < 6; k++) u_dms_panel.press(1);
    cmp_val({28'h0, pos}, 32'h4, "on phase item");
    cmp_val(dval, 32'h00000166, "phase shown");
    u_dms_panel.press(2);
    cmp_val(u_dms_panel.n_auto, 32'h1, "autophase pulse");
    u_dms_panel.press(1);
    u_dms_panel.press(3);
    rchk(8'h18, 32'h00001082, "minus on setting");
    u_dms_panel.press(2);
    u_dms_panel.press(2);
    rchk(8'h18, 32'h00001083, "plus stops at max");
    cmp_val(u_dms_panel.n_auto, 32'h1, "no autophase off phase item");
    $display("Test adjust done");
    wr(8'h18, 32'h00000083);
    wr(8'h10, 32'h00000064);
    rchk(8'h10, 32'h000001f4, "ext freq low");
    wr(8'h10, 32'h00004e20);
    rchk(8'h10, 32'h000030d4, "ext freq high");
    for (k = 0; k < 3; k++) begin
      wr(8'h18, 32'h00000083 | (k << 20));
      t1 = u_dms_panel.n_inj;
      repeat (10 * SEC) @(posedge clk);
      t1 = u_dms_panel.n_inj - t1 - (k == 0 ? 0 : k == 1 ? 10 : 100);
      cmp_val(t1 >= -1 && t1 <= 1, 1, "injection count");
    end
    wr(8'h18, 32'h00000083);
    $display("Test injection done");
    err_b <= 32'h1;
    tot_b <= 32'h4;
    det <= 1'b1;
    repeat (3 * SEC) @(posedge clk);
    rchk(8'h04, 32'h40000000, "ber live");
    axr(8'h08, rd, rs);
    cmp_val(rd >= 2 && rd <= 3, 1, "seconds count");
    err_b <= 32'h3;
    repeat (SEC) @(posedge clk);
    rchk(8'h04, 32'hc0000000, "ber recomputed");
    det <= 1'b0;
    repeat (10) @(posedge clk);
    err_b <= 32'h0;
    axr(8'h08, rd, rs);
    t1 = rd;
    repeat (3 * SEC) @(posedge clk);
    rchk(8'h04, 32'hc0000000, "ber frozen");
    rchk(8'h08, t1, "seconds frozen");
    $display("Test detector done");
    end_of_test();
  end
endmodule
`default_nettype wire
